// ===== inc/umc_pkg.sv
// Constants for the modem-control and line-status block of a UART.
// Assumes a register port with one-cycle strobes and read data a cycle later.
package umc_pkg;
  localparam logic [2:0] ADDR_MODEM_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
  localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
  localparam logic [7:0] LINE_STATUS_RST = 8'h60;
  localparam int BIT_READY = 0;
  localparam int BIT_REQUEST = 1;
  localparam int BIT_USER_OUTPUT_ONE_CTRL = 2;
  localparam int BIT_USER_OUTPUT_TWO_CTRL = 3;
  localparam int BIT_LOOP = 4;
  localparam int LS_DR = 0;
  localparam int LS_OE = 1;
  localparam int LS_PE = 2;
  localparam int LS_FE = 3;
  localparam int LS_BI = 4;
  localparam int LS_TX_HOLDING_EMPTY = 5;
  localparam int LS_TX_ALL_EMPTY = 6;
  localparam int LS_RX_FIFO_ERROR_FLAG = 7;
endpackage

// ===== verilog/umc_modem_line.sv
// Modem-control register, loopback routing and line-status flags.
// Assumes the receiver and transmitter report events as one-cycle pulses
// and give the FIFO head's error bits; FIFO storage lives elsewhere.
// Also assumes one clock, a synchronous active-low reset and
// register strobes that are one cycle long and never overlap.
`timescale 1ns/1ps
`default_nettype none
module umc_modem_line #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Receive buffer read by software (clears the head seen marker)
  input wire logic rx_data_read,
  // Modem pins
  output logic terminal_ready_pin_low,
  output logic request_send_pin_low,
  output logic user_output_one_pin_low,
  output logic user_output_two_pin_low,
  input wire logic clear_send_pin_low,
  input wire logic set_ready_pin_low,
  input wire logic ring_pin_low,
  input wire logic carrier_detect_pin_low,
  // Serial pins and shift paths
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  input wire logic tx_shift_out,
  output logic rx_shift_in,
  output logic [3:0] modem_status_level,
  // Receiver events
  input wire logic rx_char_done,
  input wire logic rx_fifo_full,
  input wire logic rx_break_seen,
  output logic rx_store,
  output logic rx_resync_start,
  input wire logic rx_frame_bad,
  // FIFO head and error count
  input wire logic rx_fifo_empty,
  input wire logic rx_head_pe,
  input wire logic rx_head_fe,
  input wire logic rx_head_bi,
  input wire logic rx_err_in,
  input wire logic rx_err_out,
  // Transmitter state
  input wire logic tx_fifo_empty,
  input wire logic tx_shift_empty,
  // Loop mode for other blocks
  output logic loop_mode
);

  // Width of the errored-character count, with one spare state
  localparam int CW = $clog2(FIFO_DEPTH + 2);

  // Control register and its next value; bits 7 to 5 are never kept
  logic [4:0] mcr_r;
  logic [4:0] mcr_nxt;

  // Read data register and its next value
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Sticky receive flags and their next values
  logic oe_r;
  logic oe_nxt;
  logic pe_r;
  logic pe_nxt;
  logic fe_r;
  logic fe_nxt;
  logic bi_r;
  logic bi_nxt;

  // Errored characters now held in the receive FIFO
  logic [CW-1:0] err_cnt_r;
  logic [CW-1:0] err_cnt_nxt;

  // Head character already looked at
  logic head_seen_r;
  logic head_seen_nxt;

  // Address and strobe decode
  logic sel_mcr;
  logic sel_lsr;
  logic wr_mcr;
  logic rd_lsr;

  // Loop mode and control bits in pin order
  logic loop;
  logic [3:0] ctl_bits;
  logic [3:0] pin_low_w;

  // Modem status levels from the pins and from the loop
  logic [3:0] pin_status;
  logic [3:0] loop_status;

  // Receive events and head character flags
  logic overrun;
  logic unused_break;
  logic head_new;
  logic head_pe;
  logic head_fe;
  logic head_bi;

  // Error count steps
  logic err_up;
  logic err_down;

  // Line status bits not held in flops
  logic ls_dr;
  logic ls_tx_holding_empty;
  logic ls_tx_all_empty;
  logic ls_rx_fifo_error_flag;
  logic [7:0] line_status;

  // Read views and read selection
  logic [7:0] mcr_view;
  logic [7:0] msr_view;
  logic [7:0] rd_mux;

  // Address decode; control and line status registers each have one select
  assign sel_mcr = (reg_addr == umc_pkg::ADDR_MODEM_CONTROL);
  assign sel_lsr = (reg_addr == umc_pkg::ADDR_LINE_STATUS);

  // Strobes qualified by address
  assign wr_mcr = reg_wr && sel_mcr;
  assign rd_lsr = reg_rd && sel_lsr; // Read clears sticky flags

  // Loop bit, also handed to the transmitter and receiver
  // Other blocks must not keep their own copy, or loop could split
  assign loop = mcr_r[umc_pkg::BIT_LOOP];
  assign loop_mode = loop;
  assign ctl_bits = mcr_r[3:0];

  // Each pin inverts its bit; loop parks all four high
  // One loop so all four pins share one form
  generate
    for (genvar g = 0; g < 4; g++) begin : gen_pin
      assign pin_low_w[g] = loop | ~ctl_bits[g];
    end
  endgenerate

  // Pins leave as separate ports
  assign terminal_ready_pin_low = pin_low_w[umc_pkg::BIT_READY];
  assign request_send_pin_low = pin_low_w[umc_pkg::BIT_REQUEST];
  assign user_output_one_pin_low = pin_low_w[umc_pkg::BIT_USER_OUTPUT_ONE_CTRL];
  assign user_output_two_pin_low = pin_low_w[umc_pkg::BIT_USER_OUTPUT_TWO_CTRL];

  // Serial output parks high in loop, so the line looks idle outside
  assign serial_out_pin = loop | tx_shift_out;
  // The receiver hears the transmitter, not the pin, in loop
  assign rx_shift_in = loop ? tx_shift_out : serial_in_pin;

  // Modem inputs as true levels: dcd, ri, dsr, cts
  assign pin_status = {
    ~carrier_detect_pin_low,
    ~ring_pin_low,
    ~set_ready_pin_low,
    ~clear_send_pin_low
  };
  // Loop image of the controls: user_output_two_ctrl, user_output_one_ctrl, request, ready
  assign loop_status = ctl_bits;
  // Pins dropped in loop so no stray change reaches the status logic
  // Change detection downstream keeps working on the looped levels
  assign modem_status_level = loop ? loop_status : pin_status;

  // A finished character is kept only while the FIFO has room
  // The dropped character never disturbs what the FIFO holds
  assign overrun = rx_char_done && rx_fifo_full;
  assign rx_store = rx_char_done && !rx_fifo_full;
  // Framing error restarts the receiver on the stop position
  assign rx_resync_start = rx_frame_bad;
  // Break reaches us as one zero character on rx_char_done already
  assign unused_break = rx_break_seen;

  // A head character is new until it has been looked at once
  assign head_new = !rx_fifo_empty && !head_seen_r;
  // Its error bits count only on that first look
  assign head_pe = head_new & rx_head_pe;
  assign head_fe = head_new & rx_head_fe;
  assign head_bi = head_new & rx_head_bi;
  // Seen until software takes the character or the FIFO drains
  always_comb begin
    head_seen_nxt = 1'b0;
    if (!rx_fifo_empty && !rx_data_read) begin
      head_seen_nxt = 1'b1;
    end
  end

  // Entry and exit in one cycle leave the count alone
  // Count holds at all ones rather than wrap to zero
  assign err_up = rx_err_in && !rx_err_out && (err_cnt_r != '1);
  // Never step below zero on a stray exit pulse
  assign err_down = !rx_err_in && rx_err_out && (err_cnt_r != '0);

  // Next error count
  always_comb begin
    err_cnt_nxt = err_cnt_r;
    if (err_up) begin
      err_cnt_nxt = err_cnt_r + CW'(1);
    end else if (err_down) begin
      err_cnt_nxt = err_cnt_r - CW'(1);
    end
  end

  // Sticky flags: the event is OR-ed in, so it wins over a clear

  // Overrun: set on a dropped character, line status read clears
  assign oe_nxt = overrun | (oe_r & ~rd_lsr);

  // Parity: set when the head shows it, line status read clears
  assign pe_nxt = head_pe | (pe_r & ~rd_lsr);

  // Framing: set when the head shows it, line status read clears
  assign fe_nxt = head_fe | (fe_r & ~rd_lsr);

  // Break: set when the zero character reaches the head
  assign bi_nxt = head_bi | (bi_r & ~rd_lsr);

  // Reserved control bits are dropped on write
  always_comb begin
    mcr_nxt = mcr_r;
    if (wr_mcr) begin
      mcr_nxt = reg_wdata[4:0];
    end
  end

  // Control register
  // Reset leaves the pins high and loop off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mcr_r <= umc_pkg::MODEM_CONTROL_RST[4:0];
    end else begin
      mcr_r <= mcr_nxt;
    end
  end

  // Overrun flag
  // Reset value taken from the line status reset word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oe_r <= umc_pkg::LINE_STATUS_RST[umc_pkg::LS_OE];
    end else begin
      oe_r <= oe_nxt;
    end
  end

  // Parity flag
  // Reset value taken from the line status reset word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pe_r <= umc_pkg::LINE_STATUS_RST[umc_pkg::LS_PE];
    end else begin
      pe_r <= pe_nxt;
    end
  end

  // Framing flag
  // Reset value taken from the line status reset word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fe_r <= umc_pkg::LINE_STATUS_RST[umc_pkg::LS_FE];
    end else begin
      fe_r <= fe_nxt;
    end
  end

  // Break flag
  // Reset value taken from the line status reset word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bi_r <= umc_pkg::LINE_STATUS_RST[umc_pkg::LS_BI];
    end else begin
      bi_r <= bi_nxt;
    end
  end

  // Head seen marker
  // Cleared at reset so a head present then is still looked at
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      head_seen_r <= 1'b0;
    end else begin
      head_seen_r <= head_seen_nxt;
    end
  end

  // Errored character count
  // Must track the FIFO exactly, or the error summary sticks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_cnt_r <= '0;
    end else begin
      err_cnt_r <= err_cnt_nxt;
    end
  end

  // Read data register
  // Zero between reads so stale data never looks valid
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Line status bits computed from levels
  assign ls_dr = ~rx_fifo_empty;
  assign ls_tx_holding_empty = tx_fifo_empty;
  assign ls_tx_all_empty = tx_fifo_empty & tx_shift_empty;
  assign ls_rx_fifo_error_flag = (err_cnt_r != '0);

  // Assembled in register order, bit 7 down to bit 0
  // Empty bits follow the transmitter live, not latched
  assign line_status = {
    ls_rx_fifo_error_flag,
    ls_tx_all_empty,
    ls_tx_holding_empty,
    bi_r,
    fe_r,
    pe_r,
    oe_r,
    ls_dr
  };

  // Reserved control bits read as zero
  assign mcr_view = {
    3'h0,
    mcr_r
  };
  // Change flags live in another block and read as zero here
  assign msr_view = {
    modem_status_level,
    4'h0
  };

  // Read selection; unmapped addresses read as zero
  // Reads have no side effect here except the line status clear
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      umc_pkg::ADDR_MODEM_CONTROL: begin
        rd_mux = mcr_view;
      end
      umc_pkg::ADDR_LINE_STATUS: begin
        rd_mux = line_status;
      end
      umc_pkg::ADDR_MODEM_STATUS: begin
        rd_mux = msr_view;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Data stand only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      rdata_nxt = rd_mux;
    end
  end

  // Read data leave straight from the flop
  assign reg_rdata = rdata_r;

endmodule
`default_nettype wire

// ===== bench/umc_checker.sv
// Checker for modem routing and receive event outputs.
// Bound to umc_modem_line; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module umc_checker (
  // Clock, reset, register port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // Pins and shift paths
  input wire logic terminal_ready_pin_low,
  input wire logic request_send_pin_low,
  input wire logic user_output_one_pin_low,
  input wire logic user_output_two_pin_low,
  input wire logic serial_out_pin,
  input wire logic tx_shift_out,
  input wire logic rx_shift_in,
  input wire logic [3:0] modem_status_level,
  input wire logic loop_mode,
  // Receiver events
  input wire logic rx_char_done,
  input wire logic rx_fifo_full,
  input wire logic rx_store,
  input wire logic rx_frame_bad,
  input wire logic rx_resync_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Control writes; loop bit decides which pins may follow
  wire ctl_wr = reg_wr && reg_addr == umc_pkg::ADDR_MODEM_CONTROL;
  wire pins_up = &{terminal_ready_pin_low, request_send_pin_low,
    user_output_one_pin_low, user_output_two_pin_low};
  ready_pin_a: assert property (ctl_wr && !reg_wdata[4] |=>
    terminal_ready_pin_low != $past(reg_wdata[0])) else $error("dtr");
  loop_pins_a: assert property (loop_mode |-> pins_up)
    else $error("pins");
  loop_serial_out_pin_a: assert property (loop_mode |-> serial_out_pin)
    else $error("serial_out_pin");
  loop_path_a: assert property (loop_mode |->
    rx_shift_in == tx_shift_out) else $error("path");
  loop_status_a: assert property (ctl_wr && reg_wdata[4] |=>
    modem_status_level == $past(reg_wdata[3:0])) else $error("msr");
  store_gate_a: assert property (rx_char_done && !rx_fifo_full
    |-> rx_store) else $error("store");
  full_drop_a: assert property (rx_fifo_full |-> !rx_store)
    else $error("drop");
  resync_a: assert property (rx_frame_bad |-> rx_resync_start)
    else $error("resync");
  cover property (loop_mode);
  cover property (rx_char_done && rx_fifo_full);
  cover property (rx_frame_bad);
endmodule
bind umc_modem_line umc_checker umc_checker_i (.*);
`default_nettype wire

// ===== bench/umc_peer.sv
// Modem peer: drives the active-low status lines and serial input.
// Lines change just after an edge, bit 4 serial, 3:0 dcd/ri/dsr/cts.
`timescale 1ns/1ps
`default_nettype none
module umc_peer (
  // Clock and wanted levels
  input wire logic clk,
  input wire logic [4:0] want,
  // Lines toward the UART
  output logic serial_in_pin,
  output logic carrier_detect_pin_low,
  output logic ring_pin_low,
  output logic set_ready_pin_low,
  output logic clear_send_pin_low
);
  // Registered so lines never move on the sampling edge
  always_ff @(posedge clk) begin
    {serial_in_pin, carrier_detect_pin_low, ring_pin_low,
      set_ready_pin_low, clear_send_pin_low} <= want;
  end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Bench for umc_modem_line with a modem peer.
// Register tasks follow the one-cycle strobe port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rx_data_read = 0;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic [4:0] want = 5'h15;
  logic tx_shift_out = 1, rx_char_done = 0, rx_fifo_full = 0;
  logic rx_break_seen = 0, rx_frame_bad = 0, rx_fifo_empty = 1;
  logic rx_head_pe = 0, rx_head_fe = 0, rx_head_bi = 0, rx_err_in = 0;
  logic rx_err_out = 0, tx_fifo_empty = 1, tx_shift_empty = 1, rx_store;
  logic rx_resync_start, loop_mode, serial_out_pin, rx_shift_in;
  logic terminal_ready_pin_low, request_send_pin_low, serial_in_pin;
  logic user_output_one_pin_low, user_output_two_pin_low, ring_pin_low;
  logic clear_send_pin_low, set_ready_pin_low, carrier_detect_pin_low;
  logic [3:0] modem_status_level;
  int failures = 0, num_checks = 0, cyc = 0;
  wire [3:0] pins = {user_output_two_pin_low, user_output_one_pin_low,
    request_send_pin_low, terminal_ready_pin_low};
  umc_modem_line umc_modem_line_i (.*);
  umc_peer umc_peer_i (.*);
  always #12.5 clk = ~clk;
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
  endtask
  // Each access ends one edge later so strobes never clash
  task automatic wr(logic [2:0] a, logic [7:0] d);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
    tick;
    reg_wr <= 0;
    tick;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e);
    {reg_addr, reg_rd} <= {a, 1'h1};
    tick;
    reg_rd <= 0;
    #1 `CHK(reg_rdata, e)
    tick;
  endtask
  task automatic wrap_up;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far above the ~70 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    tick(4);
    rst_n <= 1;
    tick;
    rd(5, 8'h60);
    rd(7, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(4, 8'h1 << i);
      `CHK(pins, ~(4'h1 << i))
    end
    wr(4, 8'hFF);
    rd(4, 8'h1F);
    `CHK({pins, serial_out_pin, modem_status_level}, 9'h1FF)
    tx_shift_out <= 0;
    tick;
    `CHK(rx_shift_in, 1'h0)
    wr(4, 8'h00);
    `CHK({modem_status_level, rx_shift_in}, {~want[3:0], want[4]})
    {rx_char_done, rx_fifo_full} <= 2'h3;
    tick;
    {rx_char_done, rx_fifo_full} <= 2'h0;
    tick;
    rd(5, 8'h62);
    rd(5, 8'h60);
    // Each pass shows a new head carrying one error kind
    for (int i = 0; i < 3; i++) begin
      {rx_head_bi, rx_head_fe, rx_head_pe, rx_fifo_empty} <= 4'h2 << i;
      tick(2);
      rd(5, 8'h61 | (8'h4 << i));
      rd(5, 8'h61);
      {rx_data_read, rx_fifo_empty} <= 2'h3;
      tick;
      rx_data_read <= 0;
    end
    rx_err_in <= 1;
    tick;
    rx_err_in <= 0;
    rd(5, 8'hE0);
    rd(5, 8'hE0);
    rx_err_out <= 1;
    tick;
    rx_err_out <= 0;
    rd(5, 8'h60);
    tx_fifo_empty <= 0;
    tick;
    rd(5, 8'h00);
    {tx_fifo_empty, tx_shift_empty} <= 2'h2;
    tick;
    rd(5, 8'h20);
    rx_frame_bad <= 1;
    tick;
    rx_frame_bad <= 0;
    tick(2);
    wrap_up;
  end
endmodule
`default_nettype wire
